// [verilog/twmts_pkg.sv]
// Constants, carrier types and states of the two-wire master sequencer.
// Assumes a single 125 MHz clock and an open-drain two-wire bus outside.
package twmts_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_PERIOD_NS = 10000;
  localparam int QTR_CYC = BIT_PERIOD_NS / 4 / CLK_PERIOD_NS;

  // ****************************************************************
  // Status codes and masks
  // ****************************************************************
  localparam logic [7:0] CODE_MASK = 8'hf8;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RESTART = 8'h10;
  localparam logic [7:0] ADDR_ACKED_CODE = 8'h18;
  localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
  localparam logic [7:0] DATA_ACKED_CODE = 8'h28;
  localparam logic [7:0] CODE_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_RADDR_ACK = 8'h40;
  localparam logic [7:0] CODE_RADDR_NACK = 8'h48;
  localparam logic [7:0] CODE_RDATA_ACK = 8'h50;
  localparam logic [7:0] CODE_RDATA_NACK = 8'h58;
  localparam logic [7:0] CODE_IDLE = 8'hf8;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [3:0] ACK_BIT_IDX = 4'd8;
  localparam logic [1:0] Q_LAST = 2'd3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_WAIT, S_START, S_BYTE, S_STOP
  } twmts_state_t;

  typedef enum logic [1:0] {
    MASTER_SEND_MODE, MASTER_RECEIVE_MODE,
    SLAVE_SEND_MODE, SLAVE_RECEIVE_MODE
  } twmts_mode_t;

  // Value written to link_control_reg
  typedef struct packed {
    logic flag_clear;
    logic ack_en;
    logic start_req;
    logic stop_req;
    logic enable;
    logic [1:0] presc;
  } twmts_ctrl_t;

  // Open-drain pin: oe high pulls the line low
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } twmts_pins_t;

endpackage : twmts_pkg

// [verilog/twmts_tick.sv]
// Quarter-bit enable divider for the two-wire sequencer.
// Assumes the caller holds run low whenever no bus phase is in progress.
module twmts_tick
  import twmts_pkg::*;
#(
  parameter int DIV = QTR_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic run,
  output logic tick
);

  if (DIV < 2) begin : g_bad_div
    $error("twmts_tick: DIV must be at least 2");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } twmts_tick_st_t;

  twmts_tick_st_t tick_reg, tick_next;

  always_comb begin
    tick_next = tick_reg;
    tick_next.tick = 1'b0;
    if (!run) begin
      tick_next.cnt = 16'h0000;
    end else if (tick_reg.cnt == 16'(DIV - 1)) begin
      tick_next.cnt = 16'h0000;
      tick_next.tick = 1'b1;
    end else begin
      tick_next.cnt = tick_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg.tick;

endmodule // twmts_tick

// [verilog/twmts_seq.sv]
// Two-wire master sequencer: control, data and status on plain ports,
// open-drain clock and data pins toward the bus.
// Assumes pin inputs are synchronous to mclk and software keeps the
// documented write order (data first, then control).
module twmts_seq
  import twmts_pkg::*;
#(
  parameter int QTR_DIV = QTR_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ctrl_wr,
  input wire twmts_ctrl_t ctrl_wdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic op_done,
  output logic write_collision,
  output logic [7:0] link_status_reg,
  output logic [7:0] link_data_reg,
  output twmts_mode_t mode
);

  if (QTR_DIV < 2) begin : g_bad_div
    $error("twmts_seq: QTR_DIV must be at least 2");
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta, rst_sync_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    twmts_state_t st;
    twmts_mode_t mode;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] data;
    logic [7:0] code;
    logic [1:0] presc;
    logic flag;
    logic wc;
    logic owned;
    logic addr_ph;
    logic dir_rd;
    logic rx;
    logic ack_en;
    logic ack_seen;
    logic enable;
    logic pend_start;
    twmts_pins_t pins;
  } twmts_st_t;

  twmts_st_t r, n;
  logic tick;

  twmts_tick #(
    .DIV(QTR_DIV)
  ) u_tick (
    .mclk(mclk),
    .rst_b(rst_sync_b),
    .run(r.st == S_START || r.st == S_BYTE || r.st == S_STOP),
    .tick(tick)
  );

  function automatic logic [7:0] end_code(logic addr, logic rd,
                                         logic rx, logic ack);
    if (addr && !rd) begin
      end_code = ack ? ADDR_ACKED_CODE : CODE_ADDR_NACK;
    end else if (addr) begin
      end_code = ack ? CODE_RADDR_ACK : CODE_RADDR_NACK;
    end else if (rx) begin
      end_code = ack ? CODE_RDATA_ACK : CODE_RDATA_NACK;
    end else begin
      end_code = ack ? DATA_ACKED_CODE : CODE_DATA_NACK;
    end
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    // Data register only accepts writes while suspended
    if (data_wr) begin
      if (r.flag) begin
        n.data = data_wdata;
        n.wc = 1'b0;
      end else begin
        n.wc = 1'b1;
      end
    end
    unique case (r.st)
      S_IDLE: begin
        n.pins = '0;
        if (r.pend_start && r.enable && sda_in && scl_in) begin
          n.st = S_START;
          n.q = 2'd0;
          n.pend_start = 1'b0;
        end
      end
      S_WAIT: begin
        n.pins.scl_oe = 1'b1;
      end
      S_START: begin
        if (tick) begin
          n.q = r.q + 2'd1;
          unique case (r.q)
            2'd0: begin
              n.pins.sda_oe = 1'b0;
              n.pins.scl_oe = r.owned;
            end
            2'd1: n.pins.scl_oe = 1'b0;
            2'd2: begin
              if (scl_in) begin
                n.pins.sda_oe = 1'b1;
              end else begin
                n.q = r.q;
              end
            end
            2'd3: begin
              n.pins.scl_oe = 1'b1;
              n.flag = 1'b1;
              n.code = r.owned ? CODE_RESTART : CODE_START;
              n.owned = 1'b1;
              n.addr_ph = 1'b1;
              n.rx = 1'b0;
              n.st = S_WAIT;
            end
          endcase
        end
      end
      S_BYTE: begin
        if (tick) begin
          n.q = r.q + 2'd1;
          unique case (r.q)
            2'd0: begin
              if (r.bitn == ACK_BIT_IDX) begin
                n.pins.sda_oe = r.rx && r.ack_en;
              end else begin
                n.pins.sda_oe = !r.rx && !r.sh[7];
              end
            end
            2'd1: n.pins.scl_oe = 1'b0;
            2'd2: begin
              if (!scl_in) begin
                n.q = r.q;
              end else if (r.bitn == ACK_BIT_IDX) begin
                n.ack_seen = r.rx ? r.ack_en : !sda_in;
              end else begin
                n.sh = {r.sh[6:0], sda_in};
              end
            end
            2'd3: begin
              n.pins.scl_oe = 1'b1;
              if (r.bitn == ACK_BIT_IDX) begin
                // Whole byte and its acknowledge are done
                n.flag = 1'b1;
                n.code = end_code(r.addr_ph, r.dir_rd, r.rx, r.ack_seen);
                if (r.rx) begin
                  n.data = r.sh;
                end
                if (r.addr_ph) begin
                  n.rx = r.dir_rd && r.ack_seen;
                  n.mode = r.dir_rd ? MASTER_RECEIVE_MODE
                                    : MASTER_SEND_MODE;
                end
                n.addr_ph = 1'b0;
                n.st = S_WAIT;
              end else begin
                n.bitn = r.bitn + 4'd1;
              end
            end
          endcase
        end
      end
      S_STOP: begin
        if (tick) begin
          n.q = r.q + 2'd1;
          unique case (r.q)
            2'd0: begin
              n.pins.sda_oe = 1'b1;
              n.pins.scl_oe = 1'b1;
            end
            2'd1: n.pins.scl_oe = 1'b0;
            2'd2: begin
              if (scl_in) begin
                n.pins.sda_oe = 1'b0;
              end else begin
                n.q = r.q;
              end
            end
            2'd3: begin
              n.owned = 1'b0;
              n.st = S_IDLE;
            end
          endcase
        end
      end
      default: n.st = S_IDLE;
    endcase
    // Software action on the control register
    if (ctrl_wr) begin
      n.enable = ctrl_wdata.enable;
      n.ack_en = ctrl_wdata.ack_en;
      n.presc = ctrl_wdata.presc;
      if (!ctrl_wdata.enable) begin
        n.st = S_IDLE;
        n.flag = 1'b0;
        n.owned = 1'b0;
        n.pend_start = 1'b0;
        n.pins = '0;
        n.code = CODE_IDLE;
      end else if (ctrl_wdata.flag_clear && r.flag) begin
        n.flag = 1'b0;
        n.q = 2'd0;
        if (ctrl_wdata.stop_req) begin
          n.st = S_STOP;
          n.pend_start = ctrl_wdata.start_req;
        end else if (ctrl_wdata.start_req) begin
          n.st = S_START;
        end else begin
          n.st = S_BYTE;
          n.sh = r.data;
          n.bitn = 4'd0;
          if (r.addr_ph) begin
            n.dir_rd = r.data[0];
          end
        end
      end else if (ctrl_wdata.flag_clear && ctrl_wdata.start_req &&
                   r.st == S_IDLE) begin
        n.pend_start = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      r <= '{st: S_IDLE, mode: MASTER_SEND_MODE, code: CODE_IDLE,
             data: DATA_RESET, default: '0};
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.pins.scl_oe;
  assign sda_oe = r.pins.sda_oe;
  assign op_done = r.flag;
  assign write_collision = r.wc;
  assign link_status_reg = {r.code[7:3], 1'b0, r.presc};
  assign link_data_reg = r.data;
  assign mode = r.mode;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_b);

  flag_suspend_a: assert property (
    r.flag && !(ctrl_wr && (ctrl_wdata.flag_clear || !ctrl_wdata.enable))
      |=>
      r.flag && r.st == S_WAIT)
    else $error("Transfer resumed while flag set");
  scl_stretch_a: assert property (
    r.flag |-> scl_oe && !scl_out)
    else $error("Clock line released while flag set");
  flag_clear_a: assert property (
    ctrl_wr && ctrl_wdata.enable && ctrl_wdata.flag_clear && r.flag
      |=> !r.flag ##1 !r.flag)
    else $error("Writing one did not clear flag");
  flag_keep_a: assert property (
    ctrl_wr && ctrl_wdata.enable && !ctrl_wdata.flag_clear && r.flag
      |=> r.flag)
    else $error("Writing zero cleared flag");
  start_code_a: assert property (
    $rose(r.flag) && $past(r.st) == S_START && !$past(r.owned) |->
      (link_status_reg & CODE_MASK) == CODE_START)
    else $error("Wrong status after start");
  start_seq_a: assert property (
    ctrl_wr && ctrl_wdata.enable && ctrl_wdata.flag_clear &&
    ctrl_wdata.start_req && !ctrl_wdata.stop_req && r.flag
      |=> r.st == S_START)
    else $error("Start request not taken");
  byte_seq_a: assert property (
    ctrl_wr && ctrl_wdata.enable && ctrl_wdata.flag_clear &&
    !ctrl_wdata.start_req && !ctrl_wdata.stop_req && r.flag
      |=> r.st == S_BYTE && r.bitn == 4'd0 && r.sh == $past(r.data))
    else $error("Byte transfer not started");
  nine_bits_a: assert property (
    $rose(r.flag) && $past(r.st) == S_BYTE |->
      $past(r.bitn) == ACK_BIT_IDX)
    else $error("Flag set before ninth bit");
  stop_noflag_a: assert property (
    $rose(r.flag) |-> $past(r.st) != S_STOP)
    else $error("Flag set after stop");
  addr_code_a: assert property (
    $rose(r.flag) && $past(r.st) == S_BYTE && $past(r.addr_ph) &&
    !$past(r.dir_rd) |->
      r.code == ($past(r.ack_seen) ? ADDR_ACKED_CODE : CODE_ADDR_NACK))
    else $error("Address status does not match acknowledge");
  dir_bit_a: assert property (
    r.st == S_BYTE && r.addr_ph && r.bitn == 4'd7 && r.q == 2'd2 |->
      sda_oe == !r.dir_rd)
    else $error("Direction bit level wrong");

  start_seen_c: cover property ($rose(r.flag) && r.code == CODE_START);
  addr_ack_c: cover property ($rose(r.flag) && r.code == ADDR_ACKED_CODE);
  data_ack_c: cover property ($rose(r.flag) && r.code == DATA_ACKED_CODE);
  stop_done_c: cover property (r.st == S_STOP ##1 r.st == S_IDLE);

endmodule // twmts_seq

// [verif/twmts_slave_model.sv]
// Slave device on the two-wire bus: counts frames, acks, stretches SCL.
// Assumes resolved open-drain levels on scl and sda, pulled up when free.
module twmts_slave_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic [3:0] stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] last_byte,
  output logic [7:0] byte_cnt,
  output logic [7:0] start_cnt,
  output logic [7:0] stop_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q;
  logic [3:0] bit_cnt, hold;
  logic [7:0] shift;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_q, sda_q} <= 2'h3;
      {scl_oe, sda_oe, bit_cnt, hold, shift} <= '0;
      {last_byte, byte_cnt, start_cnt, stop_cnt} <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        bit_cnt <= 4'h0;
        start_cnt <= start_cnt + 8'h1;
      end else if (scl && scl_q && !sda_q && sda) begin
        stop_cnt <= stop_cnt + 8'h1;
      end else if (!scl_q && scl) begin
        // Eight bits MSB first, then the acknowledge slot
        if (bit_cnt < 4'h8) begin
          shift <= {shift[6:0], sda};
          if (bit_cnt == 4'h7) begin
            last_byte <= {shift[6:0], sda};
            byte_cnt <= byte_cnt + 8'h1;
          end
        end
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_q && !scl) begin
        hold <= stretch;
        scl_oe <= (stretch != 4'h0);
        if (bit_cnt == 4'h8) sda_oe <= ack_en;
        if (bit_cnt == 4'h9) begin
          sda_oe <= 1'b0;
          bit_cnt <= 4'h0;
        end
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
        scl_oe <= (hold != 4'h1);
      end
    end
  end
endmodule // twmts_slave_model

// [verif/tb_two_wire_master_tx_sequencer.sv]
// Self-checking bench for the two-wire master sequencer.
// Assumes one slave model on the bus and pull-ups on both lines.
module tb_two_wire_master_tx_sequencer
  import twmts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam twmts_ctrl_t C_START = 7'h55;
  localparam twmts_ctrl_t C_NEXT = 7'h45;
  localparam twmts_ctrl_t C_STOP = 7'h4d;
  localparam twmts_ctrl_t C_HOLD = 7'h05;
  logic mclk = 1'b0;
  logic rst_b, ctrl_wr, data_wr, s_ack, write_collision;
  logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, op_done, scl_out, sda_out;
  logic [3:0] s_stretch;
  logic [7:0] data_wdata, status, data_q;
  logic [7:0] last_byte, byte_cnt, start_cnt, stop_cnt;
  twmts_ctrl_t ctrl_wdata;
  twmts_mode_t mode;
  int miscompares = 0;
  int check_count = 0;
  wire logic scl_bus = ~(scl_oe | s_scl_oe);
  wire logic sda_bus = ~(sda_oe | s_sda_oe);
  always #4 mclk = ~mclk;
  twmts_seq #(.QTR_DIV(4)) i_twmts_seq (.mclk(mclk), .rst_b(rst_b),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .data_wr(data_wr),
    .data_wdata(data_wdata), .scl_in(scl_bus), .sda_in(sda_bus),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .op_done(op_done), .write_collision(write_collision),
    .link_status_reg(status), .link_data_reg(data_q), .mode(mode));
  twmts_slave_model i_twmts_slave_model (.mclk(mclk), .rst_b(rst_b),
    .scl(scl_bus), .sda(sda_bus), .ack_en(s_ack), .stretch(s_stretch),
    .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .last_byte(last_byte),
    .byte_cnt(byte_cnt), .start_cnt(start_cnt), .stop_cnt(stop_cnt));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_ctrl(input twmts_ctrl_t v);
    @(negedge mclk);
    ctrl_wdata = v;
    ctrl_wr = 1'b1;
    @(negedge mclk);
    ctrl_wr = 1'b0;
  endtask
  task automatic wr_data(input logic [7:0] v);
    @(negedge mclk);
    data_wdata = v;
    data_wr = 1'b1;
    @(negedge mclk);
    data_wr = 1'b0;
  endtask
  // Bounded wait for the flag; a timeout shows as a mismatch
  task automatic wait_done;
    int n;
    n = 0;
    while (op_done !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h0, op_done}, 8'h01);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_idle;
    logic [7:0] s0;
    s0 = start_cnt;
    chk(status, CODE_IDLE);
    wr_ctrl(C_NEXT);
    wr_data(8'h96);
    repeat (40) @(negedge mclk);
    chk({7'h0, op_done}, 8'h00);
    chk(start_cnt, s0);
    chk({7'h0, write_collision}, 8'h01);
    chk(data_q, DATA_RESET);
    $display("t_idle done");
  endtask
  task automatic t_start(input logic [7:0] code);
    logic [7:0] s0;
    s0 = start_cnt;
    wr_ctrl(C_START);
    wait_done();
    chk(status & CODE_MASK, code);
    chk(start_cnt, s0 + 8'h1);
    wr_ctrl(C_HOLD);
    repeat (40) @(negedge mclk);
    chk({6'h0, op_done, scl_bus}, 8'h02);
    chk({6'h0, scl_out, sda_out}, 8'h00);
    $display("t_start %h done", code);
  endtask
  task automatic t_byte(input logic [7:0] b, input logic adr, input logic ack);
    logic [7:0] n0, code;
    n0 = byte_cnt;
    code = ack ? DATA_ACKED_CODE : CODE_DATA_NACK;
    if (adr && b[0]) code = ack ? CODE_RADDR_ACK : CODE_RADDR_NACK;
    if (adr && !b[0]) code = ack ? ADDR_ACKED_CODE : CODE_ADDR_NACK;
    s_ack = ack;
    wr_data(b);
    chk(data_q, b);
    chk({7'h0, write_collision}, 8'h00);
    wr_ctrl(C_NEXT);
    chk({7'h0, op_done}, 8'h00);
    wait_done();
    chk(last_byte, b);
    chk(byte_cnt, n0 + 8'h1);
    // Slave lets go of its acknowledge one edge after the clock falls
    @(negedge mclk);
    chk({6'h0, s_sda_oe, scl_bus}, 8'h00);
    chk(status & CODE_MASK, code);
    if (adr) chk({6'h0, mode}, {7'h0, b[0]});
    $display("t_byte %h done", b);
  endtask
  task automatic t_stop;
    logic [7:0] s0;
    s0 = stop_cnt;
    wr_ctrl(C_STOP);
    repeat (200) @(negedge mclk);
    chk(stop_cnt, s0 + 8'h1);
    chk({5'h0, op_done, scl_oe, sda_oe}, 8'h00);
    $display("t_stop done");
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    {ctrl_wr, data_wr, ctrl_wdata, data_wdata} = '0;
    s_ack = 1'b1;
    s_stretch = 4'h0;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    t_idle();
    t_start(CODE_START);
    t_byte(8'ha4, 1'b1, 1'b1);
    t_byte(8'h5a, 1'b0, 1'b1);
    s_stretch = 4'ha;
    t_byte(8'h81, 1'b0, 1'b1);
    s_stretch = 4'h0;
    t_byte(8'h3c, 1'b0, 1'b0);
    t_start(CODE_RESTART);
    t_byte(8'ha5, 1'b1, 1'b1);
    t_stop();
    t_start(CODE_START);
    t_byte(8'h4e, 1'b1, 1'b0);
    t_stop();
    give_verdict();
  end
  initial begin
    #200000;
    miscompares++;
    $display("Error at %0t ns: watchdog expired", $time);
    give_verdict();
  end
endmodule // tb_two_wire_master_tx_sequencer
